// ==== hdl/volume_ctrl_defs.vh ====
// constants for the serial volume control latch
// assumes inclusion by bare name from hdl/ modules
`ifndef VOLUME_CTRL_DEFS_VH
`define VOLUME_CTRL_DEFS_VH
// word layout, first bit shifted lands in bit 31
`define WORD_BITS 32
`define PAD_HI 31
`define PAD_LO 30
`define INSEL_HI 29
`define INSEL_LO 28
`define LOUD_POS 27
`define VOLC1_HI 26
`define VOLC1_LO 23
`define VOLF1_HI 22
`define VOLF1_LO 20
`define VOLC2_HI 19
`define VOLC2_LO 16
`define VOLF2_HI 15
`define VOLF2_LO 13
`define BASS_HI 12
`define BASS_LO 9
`define TREB_HI 8
`define TREB_LO 5
`define FADE_HI 4
`define FADE_LO 1
`define FSEL_POS 0
// settings after power-up: input 1, coarse 0dB, fine -7dB, loud off,
// tone 0dB (cut, 0 step), fader 0dB on rear
`define RESET_WORD 32'h078f0000
// apb register byte addresses
`define ADDR_SHIFT 12'h000
`define ADDR_LATCH 12'h004
`define ADDR_ACTIVE 12'h008
`define ADDR_STATUS 12'h00c
`define ADDR_TIMER 12'h010
// waiting period, 500 us with the 0.01 uF part
`define WAIT_US 500
`define CLK_MHZ 10
`define WAIT_CYCLES (`WAIT_US * `CLK_MHZ)
`define STAT_PENDING 0
`define STAT_FORCED 1
`define STAT_ZERO 2
`define STAT_BITS_LO 3
`define STAT_BITS_HI 9
`endif

// ==== hdl/pin_sync.v ====
// three-stage synchroniser for one pin
// assumes the pin is asynchronous to clk
`timescale 1ns/1ps
module pin_sync #(
	parameter RESET_VAL = 1'b0
) (
	input wire clk,
	input wire rst_n,
	input wire pin,
	output reg level
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;
	// level moves only once stages two and three agree
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_reg <= RESET_VAL;
			s2_reg <= RESET_VAL;
			s3_reg <= RESET_VAL;
			level <= RESET_VAL;
		end
		else
		begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
				level <= s3_reg;
		end
	end
endmodule // pin_sync

// ==== hdl/wait_timer.v ====
// down counter for the zero-crossing waiting period
// assumes start is a one-cycle pulse on clk
`timescale 1ns/1ps
module wait_timer #(
	parameter WIDTH = 24
) (
	input wire clk,
	input wire rst_n,
	input wire start,
	input wire stop,
	input wire [WIDTH-1:0] period,
	output wire expired,
	output wire running
);
	reg [WIDTH-1:0] count_reg;
	reg run_reg;
	assign running = run_reg;
	assign expired = run_reg && (count_reg == {{(WIDTH-1){1'b0}}, 1'b1});
	// restart wins over stop so a new word always gets a full period
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_reg <= {WIDTH{1'b0}};
			run_reg <= 1'b0;
		end
		else if (start)
		begin
			count_reg <= (period == {WIDTH{1'b0}}) ? {{(WIDTH-1){1'b0}}, 1'b1} : period;
			run_reg <= 1'b1;
		end
		else if (stop || expired)
			run_reg <= 1'b0;
		else if (run_reg)
			count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
	end
endmodule // wait_timer

// ==== hdl/volume_ctrl_latch.v ====
// serial setting word receiver, latch and zero-cross update with apb view
// assumes data, serial clock, strobe and zero-cross come from outside pclk
// Behaviour
// RULE1: one transfer carries a 32-bit word on data, serial clock and strobe.
// RULE2: data is shifted in on each rising serial clock edge.
// RULE3: strobe falling copies the shift register into the setting latch.
// RULE4: shift register and latch take reset values at power-up, no reset pin. Here both load the reset word while presetn is low.
// RULE5: the host restores defaults by sending the post-reset word.
// RULE6: the host keeps the strobe high until its first transfer.
// RULE7: latched settings reach the audio path at the first zero crossing.
// RULE8: with no zero crossing in the waiting period the update is forced.
// RULE9: the waiting period is about 500 us for the 0.01 uF timer part.
// RULE10: the period scales linearly with timer capacitance.
// RULE11: loudness follows one dedicated bit of the word.
// RULE12: fader attenuation goes to the front or rear pair by the select bit.
// RULE13: msb first; pad, input, loudness, volumes, tone, fader, select last.
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "volume_ctrl_defs.vh"
module volume_ctrl_latch #(
	parameter WAIT_CYCLES = `WAIT_CYCLES,
	parameter TW = 24
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire ser_data,
	input wire ser_clk,
	input wire latch_strobe,
	input wire zero_cross,
	output reg [1:0] input_select,
	output reg loudness_enable_bit,
	output reg [3:0] vol_coarse_1,
	output reg [2:0] vol_fine_1,
	output reg [3:0] vol_coarse_2,
	output reg [2:0] vol_fine_2,
	output reg [3:0] bass_setting,
	output reg [3:0] treble_setting,
	output reg [3:0] front_atten,
	output reg [3:0] rear_atten,
	output wire update_pending
);
	wire data_s;
	wire clk_s;
	wire strobe_s;
	wire zero_s;
	reg clk_d_reg;
	reg strobe_d_reg;
	reg zero_d_reg;
	reg [31:0] shift_reg;
	reg [31:0] latch_reg;
	reg [31:0] active_reg;
	reg forced_reg;
	reg zero_seen_reg;
	reg [TW-1:0] period_reg;
	wire clk_rise;
	wire strobe_fall;
	wire zero_edge;
	wire timer_expired;
	wire timer_running;
	wire apply;
	wire wr;
	wire rd;
	wire addr_ok;
	wire [3:0] pins_raw;
	wire [3:0] pins_s;
	reg [6:0] bit_cnt_reg;
	reg [6:0] frame_bits_reg;
	reg [31:0] status_word;

	// pins cross into pclk, strobe idles high so its stage resets high
	localparam [3:0] PIN_IDLE = 4'h4;
	assign pins_raw = {zero_cross, latch_strobe, ser_clk, ser_data};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_sync
			pin_sync #(.RESET_VAL(PIN_IDLE[gi])) u_sync (
				.clk(pclk),
				.rst_n(presetn),
				.pin(pins_raw[gi]),
				.level(pins_s[gi])
			);
		end
	endgenerate
	assign data_s = pins_s[0];
	assign clk_s = pins_s[1];
	assign strobe_s = pins_s[2]; // [RULE6]
	assign zero_s = pins_s[3];

	// edge finders on the filtered levels
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clk_d_reg <= 1'b0;
			strobe_d_reg <= 1'b1;
			zero_d_reg <= 1'b0;
		end
		else
		begin
			clk_d_reg <= clk_s;
			strobe_d_reg <= strobe_s;
			zero_d_reg <= zero_s;
		end
	end
	assign clk_rise = clk_s && !clk_d_reg;
	assign strobe_fall = !strobe_s && strobe_d_reg;
	assign zero_edge = zero_s && !zero_d_reg; // near-zero indication arrives

	// shift in msb first; only the last 32 bits before the strobe count
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			shift_reg <= `RESET_WORD; // [RULE4]
		else if (clk_rise)
			shift_reg <= {shift_reg[30:0], data_s}; // [RULE2] [RULE13] [RULE1]
	end

	// bits seen since the last strobe fall; a short frame leaves stale bits in the word
	// and a long one loses its first bits, so software can read back how many arrived
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bit_cnt_reg <= 7'h00;
			frame_bits_reg <= 7'h00;
		end
		else if (strobe_fall)
		begin
			bit_cnt_reg <= 7'h00;
			frame_bits_reg <= bit_cnt_reg; // [RULE1]
		end
		else if (clk_rise && (bit_cnt_reg != 7'h7f))
			bit_cnt_reg <= bit_cnt_reg + 7'h01; // saturates, never wraps to a false 32
	end

	// latch on strobe fall, a clock edge in the same cycle is not seen
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			latch_reg <= `RESET_WORD; // [RULE4]
		else if (strobe_fall)
			latch_reg <= shift_reg; // [RULE3]
	end

	// waiting period runs from strobe fall; capacitor value is modelled by period_reg
	wait_timer #(.WIDTH(TW)) u_timer (
		.clk(pclk),
		.rst_n(presetn),
		.start(strobe_fall),
		.stop(zero_edge),
		.period(period_reg),
		.expired(timer_expired),
		.running(timer_running)
	);
	assign update_pending = timer_running;
	// zero edge in the strobe cycle is ignored: the new word needs a later crossing
	assign apply = timer_running && !strobe_fall && (zero_edge || timer_expired); // [RULE7] [RULE8]

	// settings that the audio path really uses
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			active_reg <= `RESET_WORD; // [RULE4]
			forced_reg <= 1'b0;
			zero_seen_reg <= 1'b0;
		end
		else if (apply)
		begin
			active_reg <= latch_reg; // [RULE7]
			forced_reg <= !zero_edge; // [RULE8]
			zero_seen_reg <= zero_edge;
		end
	end

	// input selector and loudness from the applied word
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			input_select <= 2'h0;
			loudness_enable_bit <= 1'b0;
		end
		else
		begin
			input_select <= active_reg[`INSEL_HI:`INSEL_LO];
			loudness_enable_bit <= active_reg[`LOUD_POS]; // [RULE11]
		end
	end

	// channel 1 volume, reset decode matches the post-reset word
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			vol_coarse_1 <= 4'hf;
			vol_fine_1 <= 3'h0;
		end
		else
		begin
			vol_coarse_1 <= active_reg[`VOLC1_HI:`VOLC1_LO];
			vol_fine_1 <= active_reg[`VOLF1_HI:`VOLF1_LO];
		end
	end

	// channel 2 volume, set apart from channel 1 so balance works
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			vol_coarse_2 <= 4'hf;
			vol_fine_2 <= 3'h0;
		end
		else
		begin
			vol_coarse_2 <= active_reg[`VOLC2_HI:`VOLC2_LO];
			vol_fine_2 <= active_reg[`VOLF2_HI:`VOLF2_LO];
		end
	end

	// tone settings, boost or cut bit kept inside each field
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bass_setting <= 4'h0;
			treble_setting <= 4'h0;
		end
		else
		begin
			bass_setting <= active_reg[`BASS_HI:`BASS_LO];
			treble_setting <= active_reg[`TREB_HI:`TREB_LO];
		end
	end

	// fader: one pair takes the attenuation, the unselected pair stays at 0 dB
	// so a select change never leaves both pairs attenuated
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			front_atten <= 4'h0;
			rear_atten <= 4'h0;
		end
		else
		begin
			front_atten <= active_reg[`FSEL_POS] ? active_reg[`FADE_HI:`FADE_LO] : 4'h0; // [RULE12]
			rear_atten <= active_reg[`FSEL_POS] ? 4'h0 : active_reg[`FADE_HI:`FADE_LO]; // [RULE12]
		end
	end

	// apb slave, zero wait states
	assign pready = 1'b1;
	assign addr_ok = (paddr == `ADDR_SHIFT) || (paddr == `ADDR_LATCH) ||
		(paddr == `ADDR_ACTIVE) || (paddr == `ADDR_STATUS) || (paddr == `ADDR_TIMER);
	assign pslverr = psel && penable && !addr_ok;
	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;

	// timer period register stands in for the timer capacitor
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			period_reg <= WAIT_CYCLES[TW-1:0]; // [RULE9]
		else if (wr && (paddr == `ADDR_TIMER))
			period_reg <= pwdata[TW-1:0]; // [RULE10]
	end

	// status word, assembled from the field positions in the header
	// unused bits read zero
	always @*
	begin
		status_word = 32'h00000000;
		status_word[`STAT_PENDING] = timer_running;
		status_word[`STAT_FORCED] = forced_reg;
		status_word[`STAT_ZERO] = zero_seen_reg;
		status_word[`STAT_BITS_HI:`STAT_BITS_LO] = frame_bits_reg; // [RULE1]
	end

	// read data captured in setup so it stands through access
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (rd)
		begin
			case (paddr)
				`ADDR_SHIFT: prdata <= shift_reg;
				`ADDR_LATCH: prdata <= latch_reg;
				`ADDR_ACTIVE: prdata <= active_reg;
				`ADDR_STATUS: prdata <= status_word;
				`ADDR_TIMER: prdata <= {{(32-TW){1'b0}}, period_reg};
				default: prdata <= 32'h00000000;
			endcase
		end
	end
endmodule // volume_ctrl_latch

// ==== testbench/volume_ctrl_sva.sv ====
// checker on the apb and update ports of the volume latch
// assumes a bind into the design top, one clock domain
`timescale 1ns/1ps
module volume_ctrl_sva #(
	parameter WAIT_CYCLES = 5000
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire zero_cross,
	input wire [3:0] vol_coarse_1,
	input wire [3:0] front_atten,
	input wire [3:0] rear_atten,
	input wire update_pending
);
	logic [23:0] per_reg, run_reg;
	wire unmapped = paddr > 12'h010 || paddr[1:0] != 2'h0;
	wire [11:0] outs = {vol_coarse_1, front_atten, rear_atten};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// period shadow, zero acts as one; run_reg counts waiting cycles
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			{per_reg, run_reg} <= {24'(WAIT_CYCLES), 24'h0};
		else
		begin
			if (psel && penable && pwrite && paddr == 12'h010)
				per_reg <= (pwdata[23:0] == 24'h0) ? 24'h1 : pwdata[23:0];
			run_reg <= update_pending ? run_reg + 24'h1 : 24'h0;
		end
	chk_ready_high: assert property (pready) else $error("pready low");
	chk_err_unmapped: assert property (psel && penable && unmapped |-> pslverr)
		else $error("no error flag");
	chk_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data moved");
	chk_rdata_zero: assert property (psel && !penable && !pwrite && unmapped |=> !prdata)
		else $error("unmapped data");
	chk_hold_pending: assert property (update_pending [*2] |-> $stable(outs))
		else $error("moved while waiting");
	chk_hold_idle: assert property (!update_pending [*3] |-> $stable(outs))
		else $error("moved while idle");
	chk_zero_apply: assert property (
		update_pending && $rose(zero_cross) |-> ##[1:8] !update_pending)
		else $error("zero crossing ignored");
	chk_wait_bound: assert property (update_pending |-> run_reg <= per_reg)
		else $error("wait too long");
	cover property (update_pending ##1 !update_pending);
	cover property (update_pending && $rose(zero_cross));
	cover property (psel && penable && pslverr);
endmodule // volume_ctrl_sva

// ==== testbench/host_serial.sv ====
// serial host model: shifts one word in, then drops the strobe
// assumes an 800 ns link clock that stands low between frames
`timescale 1ns/1ps
module host_serial (
	output logic ser_data,
	output logic ser_clk,
	output logic latch_strobe
);
	// strobe high from power-up until a transfer
	initial {ser_data, ser_clk, latch_strobe} = 3'h1;
	// msb first; data moves mid-low so it holds 6 pclk past the rise
	task send(input [31:0] w);
		for (int i = 31; i >= 0; i--)
		begin
			ser_data <= w[i];
			#200 ser_clk <= 1'b1;
			#400 ser_clk <= 1'b0;
			#200;
		end
		ser_data <= ~w[0]; // no stale bit once released
		latch_strobe <= 1'b0;
		#800 latch_strobe <= 1'b1;
		#400;
	endtask
endmodule // host_serial

// ==== testbench/tb.sv ====
// bench for the volume latch: apb host, serial host, zero-cross pin
// assumes design, header, checker and host model compiled first
`timescale 1ns/1ps
module tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
	logic zero_cross = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, rd;
	wire [31:0] prdata;
	wire pready, pslverr, ser_data, ser_clk, latch_strobe, loudness_enable_bit, update_pending;
	wire [1:0] input_select;
	wire [3:0] vol_coarse_1, vol_coarse_2, bass_setting, treble_setting, front_atten, rear_atten;
	wire [2:0] vol_fine_1, vol_fine_2;
	wire [32:0] outs_w = {input_select, loudness_enable_bit, vol_coarse_1, vol_fine_1,
		vol_coarse_2, vol_fine_2, bass_setting, treble_setting, front_atten, rear_atten};
	int error_cnt = 0, cmp_count = 0, pend_cyc = 0;
	// post-reset word (fine -7, coarse 0), a zero-cross word, a timer word
	localparam logic [31:0] rst_w = 32'h078f0000;
	localparam logic [31:0] zc_w = 32'h2d35d2cf;
	localparam logic [31:0] tm_w = 32'h11dc25b0;
	volume_ctrl_latch #(.WAIT_CYCLES(5000)) dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.ser_data(ser_data),
		.ser_clk(ser_clk),
		.latch_strobe(latch_strobe),
		.zero_cross(zero_cross),
		.input_select(input_select),
		.loudness_enable_bit(loudness_enable_bit),
		.vol_coarse_1(vol_coarse_1),
		.vol_fine_1(vol_fine_1),
		.vol_coarse_2(vol_coarse_2),
		.vol_fine_2(vol_fine_2),
		.bass_setting(bass_setting),
		.treble_setting(treble_setting),
		.front_atten(front_atten),
		.rear_atten(rear_atten),
		.update_pending(update_pending)
	);
	host_serial host (
		.ser_data(ser_data),
		.ser_clk(ser_clk),
		.latch_strobe(latch_strobe)
	);
	always #50 pclk = ~pclk;
	always @(posedge pclk) pend_cyc += int'(update_pending === 1'b1);
	task chk(input [35:0] got, exp);
		cmp_count++;
		if (got !== exp)
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		error_cnt += int'(got !== exp);
	endtask
	// the select bit picks which pair gets the fader value
	function [32:0] exp_o(input [31:0] w);
		exp_o = {w[29:5], w[0] ? w[4:1] : 4'h0, w[0] ? 4'h0 : w[4:1]};
	endfunction
	task apb(input w, input [11:0] a, input [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		{rd, er} = {prdata, pslverr};
		{psel, penable} <= 2'h0;
	endtask
	// send a word, then a zero pulse or let the timer run for per cycles
	task apply(input [31:0] w, prev, input zc, input int per);
		pend_cyc = 0;
		host.send(w);
		chk({update_pending, outs_w}, {1'b1, exp_o(prev)});
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, w);
		zero_cross <= zc;
		repeat (4) @(posedge pclk);
		zero_cross <= 1'b0;
		repeat (100) if (update_pending !== 1'b0) @(posedge pclk);
		repeat (3) @(posedge pclk);
		apb(1'b0, 12'h00c, 32'h0);
		chk({rd[2:0], outs_w}, {zc ? 3'h4 : 3'h2, exp_o(w)});
		chk(rd[9:3], 7'h20);
		chk(zc || pend_cyc == per || pend_cyc == per + 1, 1'b1);
	endtask
	task t_reset;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		chk(outs_w, exp_o(rst_w));
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, rst_w);
	endtask
	// unmapped read flags an error and returns zero
	task t_apb;
		apb(1'b0, 12'h018, 32'h0);
		chk({er, rd}, 33'h100000000);
	endtask
	initial
	begin
		t_reset;
		apply(zc_w, rst_w, 1'b1, 0);
		t_apb;
		apb(1'b1, 12'h010, 32'h14);
		apply(tm_w, zc_w, 1'b0, 20);
		apb(1'b1, 12'h010, 32'h2d);
		apply(rst_w, tm_w, 1'b0, 45);
		finish_test;
	end
	// the run needs about 0.1 ms
	initial
	begin
		#1000000 error_cnt++;
		finish_test;
	end
	task finish_test;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
endmodule // tb
bind volume_ctrl_latch volume_ctrl_sva #(.WAIT_CYCLES(WAIT_CYCLES)) chk_i (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.zero_cross(zero_cross),
	.vol_coarse_1(vol_coarse_1),
	.front_atten(front_atten),
	.rear_atten(rear_atten),
	.update_pending(update_pending)
);
